// [rtl/cst_pkg.sv]
package cst_pkg;
  // **********************************************
  // clock and tick base
  // **********************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_NS = 100_000;
  localparam int TICK_CYC_DEF = TICK_NS / CLK_PERIOD_NS;
  localparam longint NS_PER_MS = 1_000_000;
  localparam longint NS_PER_US = 1_000;
  localparam longint MS_PER_MIN = 60_000;
  // **********************************************
  // safety, watchdog and interrupt timing
  // **********************************************
  localparam int PRE_TIMER_MIN = 36;
  localparam int TOT_TIMER_MIN = 240;
  localparam int WDOG_MS = 40_000;
  localparam int IRQ_PULSE_US = 800;
  localparam int IRQ_PERIOD_MS = 350;
  localparam int PRE_TICKS_DEF = int'(PRE_TIMER_MIN * MS_PER_MIN * NS_PER_MS / TICK_NS);
  localparam int TOT_TICKS_DEF = int'(TOT_TIMER_MIN * MS_PER_MIN * NS_PER_MS / TICK_NS);
  localparam int WDOG_TICKS_DEF = int'(WDOG_MS * NS_PER_MS / TICK_NS);
  localparam int IRQ_PULSE_TICKS = int'(IRQ_PULSE_US * NS_PER_US / TICK_NS);
  localparam int IRQ_PERIOD_TICKS = int'(IRQ_PERIOD_MS * NS_PER_MS / TICK_NS);
  // **********************************************
  // voltages in mV
  // **********************************************
  localparam int RECHARGE_MV = 140;
  localparam int FLOAT_BASE_MV = 3500;
  localparam int FLOAT_STEP_MV = 10;
  // **********************************************
  // widths and codes
  // **********************************************
  localparam int TICK_W = 14;
  localparam int TMR_W = 28;
  localparam int WD_W = 24;
  localparam int IRQ_W = 12;
  localparam int SYNC_W = 9;
  localparam logic [1:0] PH_TRICKLE = 2'h0;
  localparam logic [1:0] PH_PRE = 2'h1;
  localparam logic [1:0] PH_FAST = 2'h2;
  localparam logic [1:0] PH_CV = 2'h3;
  typedef enum logic [1:0] {CHG_IDLE, CHG_RUN, CHG_FULL, CHG_HOLD} cst_chg_t;
  typedef enum logic [1:0] {BST_OFF, BST_ON, BST_LOCK} cst_bst_t;
endpackage

// [rtl/cst_sync.sv]
`timescale 1ns/1ns
module cst_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_r;

  // **********************************************
  // two flop synchroniser
  // **********************************************
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_r <= '0;
      q_o <= '0;
    end else begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end
endmodule

// [rtl/cst_supervisor.sv]
// How it works
// - restart charge of a full battery when voltage falls more than 140mV below float.
// - recharge needs auto recharge bit, supply, enable and start-up conditions.
// - auto charge bit and dead battery start charge without enable control.
// - automatic charge runs until completion or pre-charge or total timer expiry.
// - boost may start only with no input supply and battery above limit.
// - boost voltage from two-bit field, current limit from fast current field.
// - battery uv, battery limit or input uv stop boost until re-enabled.
// - boost overcurrent turns boost off, flags error and overcurrent status.
// - die over temperature during boost turns it off with thermal status.
// - boost watchdog expiry turns boost off with watchdog status.
// - every acknowledged host transfer restarts the watchdog.
// - watchdog expiry suspends operation, raises interrupt, reloads defaults.
// - three enables pick standby, boost and charge watchdogs.
// - no watchdog but the boost one runs while full and awaiting recharge, unless charge disabled.
// - pre-charge timer runs through trickle and pre, resets entering fast.
// - total timer stops charging if termination not reached in time.
// - a select bit decides whether trickle time counts in timers.
// - timer clear bit clears both safety timers.
// - safety timers do not run during automatic recharge.
// - status pin low on charging or input fault, with type and off bits.
// - pending unmasked factors pulse the status pin 0.8ms every 350ms.
`timescale 1ns/1ns
module cst_supervisor #(
  parameter int unsigned TICK_CYC = cst_pkg::TICK_CYC_DEF,
  parameter int unsigned PRE_TICKS = cst_pkg::PRE_TICKS_DEF,
  parameter int unsigned TOT_TICKS = cst_pkg::TOT_TICKS_DEF,
  parameter int unsigned WDOG_TICKS = cst_pkg::WDOG_TICKS_DEF
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic input_supply_pin_i,
  input wire logic in_uvlo_i,
  input wire logic in_ovlo_i,
  input wire logic dead_battery_threshold_i,
  input wire logic limit_boost_pin_i,
  input wire logic boost_batt_ok_i,
  input wire logic boost_oc_i,
  input wire logic batt_ilim_i,
  input wire logic die_hot_i,
  input wire logic startup_ok_i,
  input wire logic charge_en_i,
  input wire logic charge_done_i,
  input wire logic [1:0] charge_phase_i,
  input wire logic [12:0] batt_mv_i,
  input wire logic [6:0] float_voltage_field_i,
  input wire logic recharge_threshold_sel_i,
  input wire logic auto_recharge_en_i,
  input wire logic auto_charge_en_i,
  input wire logic boost_host_ctrl_i,
  input wire logic boost_i2c_en_i,
  input wire logic [1:0] boost_voltage_sel_i,
  input wire logic [4:0] fast_current_field_i,
  input wire logic boost_stat_clear_i,
  input wire logic i2c_ack_i,
  input wire logic standby_wdog_en_i,
  input wire logic boost_wdog_en_i,
  input wire logic charge_wdog_en_i,
  input wire logic precharge_timer_en_i,
  input wire logic total_charge_timer_en_i,
  input wire logic trickle_time_count_sel_i,
  input wire logic safety_timer_clear_i,
  input wire logic state_pin_type_sel_i,
  input wire logic state_pin_out_en_i,
  input wire logic [6:0] irq_flags_i,
  input wire logic [6:0] irq_mask_i,
  output logic charge_run_o,
  output logic recharge_active_o,
  output logic boost_on_o,
  output logic [1:0] boost_voltage_o,
  output logic [4:0] boost_ilim_o,
  output logic boost_error_irq_o,
  output logic boost_overcurrent_stat_o,
  output logic boost_thermal_stat_o,
  output logic boost_wdog_stat_o,
  output logic charge_timer_irq_o,
  output logic wdog_irq_o,
  output logic recharge_irq_o,
  output logic reg_reload_o,
  output logic state_pin_o,
  output logic state_pin_oe_o
);
  typedef struct packed {
    cst_pkg::cst_chg_t chg;
    cst_pkg::cst_bst_t bst;
    logic auto_r;
    logic rch_r;
    logic [cst_pkg::TICK_W-1:0] tick;
    logic [cst_pkg::TMR_W-1:0] pre;
    logic [cst_pkg::TMR_W-1:0] tot;
    logic [cst_pkg::WD_W-1:0] wd;
    logic [cst_pkg::IRQ_W-1:0] irq;
    logic oc;
    logic hot;
    logic wdx;
    logic [1:0] volt;
    logic [4:0] ilim;
    logic err_p;
    logic wd_p;
    logic rch_p;
    logic tmr_p;
    logic reload;
    logic pin_low;
  } cst_state_t;

  cst_state_t st_r;
  cst_state_t st_nxt;
  logic [cst_pkg::SYNC_W-1:0] pins_s;
  logic supply_s, uvlo_s, ovlo_s, dead_s, bpin_s, batt_ok_s, oc_s, ilim_s, hot_s;
  logic tick, chg_run, bst_on, chg_req, auto_req, bst_req, wd_act, wd_exp;
  logic tr_ok, counting, pre_exp, tot_exp, rch_go, pend, pulse;

  function automatic logic hit(input logic [31:0] c, input int unsigned lim);
    return c >= 32'(lim - 1);
  endfunction

  function automatic logic [13:0] float_mv(input logic [6:0] code);
    return 14'(cst_pkg::FLOAT_BASE_MV + int'(code) * cst_pkg::FLOAT_STEP_MV);
  endfunction

  // **********************************************
  // pin synchronisers
  // **********************************************
  cst_sync #(
    .W(cst_pkg::SYNC_W)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({input_supply_pin_i, in_uvlo_i, in_ovlo_i, dead_battery_threshold_i,
      limit_boost_pin_i, boost_batt_ok_i, boost_oc_i, batt_ilim_i, die_hot_i}),
    .q_o(pins_s)
  );
  assign {supply_s, uvlo_s, ovlo_s, dead_s, bpin_s, batt_ok_s, oc_s, ilim_s, hot_s} = pins_s;

  // **********************************************
  // next state
  // **********************************************
  always_comb begin
    st_nxt = st_r;
    st_nxt.err_p = 1'b0;
    st_nxt.wd_p = 1'b0;
    st_nxt.rch_p = 1'b0;
    st_nxt.tmr_p = 1'b0;
    st_nxt.reload = 1'b0;
    tick = hit(32'(st_r.tick), TICK_CYC);
    st_nxt.tick = tick ? '0 : st_r.tick + 1'b1;
    chg_run = st_r.chg == cst_pkg::CHG_RUN;
    bst_on = st_r.bst == cst_pkg::BST_ON;
    chg_req = supply_s & startup_ok_i & charge_en_i;
    auto_req = supply_s & startup_ok_i & auto_charge_en_i & dead_s;
    // threshold select has one legal setting: 140mV
    rch_go = auto_recharge_en_i & chg_req & !recharge_threshold_sel_i
      & ({1'b0, batt_mv_i} + 14'(cst_pkg::RECHARGE_MV)
      < float_mv(float_voltage_field_i));
    bst_req = boost_host_ctrl_i ? boost_i2c_en_i : bpin_s;
    // charge sequencing
    unique case (st_r.chg)
      cst_pkg::CHG_IDLE: begin
        if (chg_req | auto_req) begin
          st_nxt.chg = cst_pkg::CHG_RUN;
          st_nxt.auto_r = auto_req & !chg_req;
          st_nxt.rch_r = 1'b0;
        end
      end
      cst_pkg::CHG_RUN: begin
        if (!supply_s | !startup_ok_i | (!st_r.auto_r & !charge_en_i)) begin
          st_nxt.chg = cst_pkg::CHG_IDLE;
        end else if (charge_done_i) begin
          st_nxt.chg = cst_pkg::CHG_FULL;
          st_nxt.auto_r = 1'b0;
        end
      end
      cst_pkg::CHG_FULL: begin
        if (!supply_s | !charge_en_i) begin
          st_nxt.chg = cst_pkg::CHG_IDLE;
        end else if (rch_go) begin
          st_nxt.chg = cst_pkg::CHG_RUN;
          st_nxt.rch_r = 1'b1;
          st_nxt.rch_p = 1'b1;
        end
      end
      cst_pkg::CHG_HOLD: begin
        if (!charge_en_i) begin
          st_nxt.chg = cst_pkg::CHG_IDLE;
        end
      end
    endcase
    // safety timers
    counting = chg_run & !st_r.rch_r;
    tr_ok = (charge_phase_i != cst_pkg::PH_TRICKLE) | trickle_time_count_sel_i;
    pre_exp = counting & precharge_timer_en_i & tr_ok & tick & hit(32'(st_r.pre), PRE_TICKS)
      & (charge_phase_i == cst_pkg::PH_TRICKLE | charge_phase_i == cst_pkg::PH_PRE);
    tot_exp = counting & total_charge_timer_en_i & tr_ok & tick & !charge_done_i
      & hit(32'(st_r.tot), TOT_TICKS);
    if (!counting | safety_timer_clear_i | charge_phase_i == cst_pkg::PH_FAST
        | charge_phase_i == cst_pkg::PH_CV) begin
      st_nxt.pre = '0;
    end else if (tick & precharge_timer_en_i & tr_ok) begin
      st_nxt.pre = st_r.pre + 1'b1;
    end
    if (st_r.chg == cst_pkg::CHG_IDLE | safety_timer_clear_i) begin
      st_nxt.tot = '0;
    end else if (counting & tick & total_charge_timer_en_i & tr_ok) begin
      st_nxt.tot = st_r.tot + 1'b1;
    end
    if (pre_exp | tot_exp) begin
      st_nxt.chg = cst_pkg::CHG_HOLD;
      st_nxt.auto_r = 1'b0;
      st_nxt.tmr_p = 1'b1;
    end
    // boost control
    st_nxt.volt = boost_voltage_sel_i;
    st_nxt.ilim = fast_current_field_i;
    unique case (st_r.bst)
      cst_pkg::BST_OFF: begin
        if (bst_req & !supply_s & batt_ok_s) begin
          st_nxt.bst = cst_pkg::BST_ON;
        end
      end
      cst_pkg::BST_ON: begin
        if (!bst_req) begin
          st_nxt.bst = cst_pkg::BST_OFF;
        end else if (oc_s | hot_s) begin
          st_nxt.bst = cst_pkg::BST_LOCK;
          st_nxt.err_p = 1'b1;
        end else if (!batt_ok_s | ilim_s | uvlo_s) begin
          st_nxt.bst = cst_pkg::BST_LOCK;
        end
      end
      cst_pkg::BST_LOCK: begin
        if (!bst_req) begin
          st_nxt.bst = cst_pkg::BST_OFF;
        end
      end
      default: st_nxt.bst = cst_pkg::BST_OFF;
    endcase
    if (boost_stat_clear_i) begin
      st_nxt.oc = 1'b0;
      st_nxt.hot = 1'b0;
      st_nxt.wdx = 1'b0;
    end
    if (bst_on & bst_req & oc_s) begin
      st_nxt.oc = 1'b1;
    end
    if (bst_on & bst_req & hot_s) begin
      st_nxt.hot = 1'b1;
    end
    // watchdog
    wd_act = (chg_run & charge_wdog_en_i) | (bst_on & boost_wdog_en_i)
      | ((st_r.chg == cst_pkg::CHG_IDLE | st_r.chg == cst_pkg::CHG_HOLD) & !bst_on
      & standby_wdog_en_i);
    wd_exp = wd_act & tick & !i2c_ack_i & hit(32'(st_r.wd), WDOG_TICKS);
    if (i2c_ack_i | !wd_act | wd_exp) begin
      st_nxt.wd = '0;
    end else if (tick) begin
      st_nxt.wd = st_r.wd + 1'b1;
    end
    if (wd_exp) begin
      st_nxt.reload = 1'b1;
      st_nxt.wd_p = 1'b1;
      if (chg_run) begin
        st_nxt.chg = cst_pkg::CHG_IDLE;
        st_nxt.auto_r = 1'b0;
      end
      if (bst_on) begin
        st_nxt.bst = cst_pkg::BST_LOCK;
        st_nxt.err_p = 1'b1;
        st_nxt.wdx = 1'b1;
      end
    end
    // interrupt pulse train and status pin
    pend = |(irq_flags_i & ~irq_mask_i);
    if (!pend) begin
      st_nxt.irq = '0;
    end else if (tick) begin
      st_nxt.irq = hit(32'(st_r.irq), cst_pkg::IRQ_PERIOD_TICKS) ? '0 : st_r.irq + 1'b1;
    end
    pulse = pend & (32'(st_r.irq) < 32'(cst_pkg::IRQ_PULSE_TICKS));
    st_nxt.pin_low = state_pin_out_en_i & (state_pin_type_sel_i ? pulse
      : (chg_run | uvlo_s | ovlo_s));
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // **********************************************
  // outputs
  // **********************************************
  assign charge_run_o = st_r.chg == cst_pkg::CHG_RUN;
  assign recharge_active_o = charge_run_o & st_r.rch_r;
  assign boost_on_o = st_r.bst == cst_pkg::BST_ON;
  assign boost_voltage_o = st_r.volt;
  assign boost_ilim_o = st_r.ilim;
  assign boost_error_irq_o = st_r.err_p;
  assign boost_overcurrent_stat_o = st_r.oc;
  assign boost_thermal_stat_o = st_r.hot;
  assign boost_wdog_stat_o = st_r.wdx;
  assign charge_timer_irq_o = st_r.tmr_p;
  assign wdog_irq_o = st_r.wd_p;
  assign recharge_irq_o = st_r.rch_p;
  assign reg_reload_o = st_r.reload;
  assign state_pin_o = 1'b0;
  assign state_pin_oe_o = st_r.pin_low;

  // **********************************************
  // assertions
  // **********************************************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_boost_fault;
    boost_on_o && bst_req && (oc_s || hot_s);
  endsequence
  sequence s_boost_off_err;
    !boost_on_o && boost_error_irq_o;
  endsequence

  a_boost_oc_off: assert property (s_boost_fault |=> s_boost_off_err)
    else $error("boost fault did not shut boost off");
  a_boost_oc_stat: assert property (boost_on_o && bst_req && oc_s |=> boost_overcurrent_stat_o)
    else $error("overcurrent status not set");
  a_boost_hot_stat: assert property (boost_on_o && bst_req && hot_s |=> boost_thermal_stat_o)
    else $error("thermal status not set");
  a_boost_start_gate: assert property ($rose(boost_on_o) |-> $past(!supply_s && batt_ok_s))
    else $error("boost started without permission");
  a_boost_lock_hold: assert property (st_r.bst == cst_pkg::BST_LOCK && bst_req
    |=> !boost_on_o)
    else $error("boost resumed without re-enable");
  a_wdog_reload: assert property (wd_exp |=> reg_reload_o && wdog_irq_o ##1 !reg_reload_o)
    else $error("watchdog expiry did not reload once");
  a_wdog_boost: assert property (wd_exp && boost_on_o |=> !boost_on_o && boost_wdog_stat_o)
    else $error("boost watchdog expiry not handled");
  a_ack_restart: assert property (i2c_ack_i |=> st_r.wd == '0)
    else $error("ack did not restart watchdog");
  a_full_no_wdog: assert property (st_r.chg == cst_pkg::CHG_FULL && !bst_on |-> !wd_act)
    else $error("watchdog active while full");
  a_recharge_start: assert property (st_r.chg == cst_pkg::CHG_FULL && supply_s && charge_en_i
    && rch_go |=> recharge_active_o && recharge_irq_o)
    else $error("recharge did not start");
  a_recharge_hold: assert property (recharge_active_o |=> st_r.pre == '0 && $stable(st_r.tot))
    else $error("safety timer ran during recharge");
  a_timer_clear: assert property (safety_timer_clear_i |=> st_r.pre == '0 && st_r.tot == '0)
    else $error("timer clear ignored");
  a_auto_start: assert property (st_r.chg == cst_pkg::CHG_IDLE && auto_req |=> charge_run_o)
    else $error("automatic charge did not start");
  a_pin_state: assert property (state_pin_out_en_i && !state_pin_type_sel_i && charge_run_o
    |=> state_pin_oe_o)
    else $error("status pin not low while charging");
  a_pulse_pending: assert property (state_pin_type_sel_i && !pend |=> !state_pin_oe_o)
    else $error("status pulse without pending factor");
  a_boost_cfg: assert property (##1 boost_ilim_o == $past(fast_current_field_i)
    && boost_voltage_o == $past(boost_voltage_sel_i))
    else $error("boost setting not taken");
endmodule

// [verification/cst_host_model.sv]
`timescale 1ns/1ns
// ***********************************************
// host model: watchdog service and factor clearing
// ***********************************************
module cst_host_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic pin_oe_i,
  input wire logic keep_alive_i,
  input wire logic auto_clear_i,
  input wire logic load_i,
  input wire logic [6:0] load_val_i,
  output logic i2c_ack_o,
  output logic [6:0] irq_flags_o,
  output logic stat_pin_o
);
  logic [5:0] gap_r;
  logic pin_q;
  // open-drain line with pull-up
  assign stat_pin_o = pin_oe_i ? 1'h0 : 1'h1;
  always @(negedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      gap_r <= 6'h00;
      i2c_ack_o <= 1'h0;
      irq_flags_o <= 7'h00;
      pin_q <= 1'h1;
    end else begin
      pin_q <= stat_pin_o;
      gap_r <= (gap_r == 6'h27) ? 6'h00 : gap_r + 6'h01;
      // one acknowledged transfer every 40 cycles keeps the watchdog fed
      i2c_ack_o <= keep_alive_i && (gap_r == 6'h27);
      if (load_i) begin
        irq_flags_o <= load_val_i;
      end else if (auto_clear_i && !pin_q && stat_pin_o) begin
        // read and clear every factor once a pulse has ended
        irq_flags_o <= 7'h00;
      end
    end
  end
endmodule

// [verification/cst_supervisor_bench.sv]
`timescale 1ns/1ns
module cst_supervisor_bench;
  // ***********************************************
  // signals, design and host model
  // ***********************************************
  logic clk_i = 1'h0, rst_i = 1'h1, input_supply_pin_i = 1'h0, in_uvlo_i = 1'h0;
  logic in_ovlo_i = 1'h0, dead_battery_threshold_i = 1'h0, limit_boost_pin_i = 1'h0;
  logic boost_batt_ok_i = 1'h0, boost_oc_i = 1'h0, batt_ilim_i = 1'h0, die_hot_i = 1'h0;
  logic startup_ok_i = 1'h0, charge_en_i = 1'h0, charge_done_i = 1'h0;
  logic recharge_threshold_sel_i = 1'h0, auto_recharge_en_i = 1'h0, auto_charge_en_i = 1'h0;
  logic boost_host_ctrl_i = 1'h0, boost_i2c_en_i = 1'h0, boost_stat_clear_i = 1'h0;
  logic standby_wdog_en_i = 1'h0, boost_wdog_en_i = 1'h0, charge_wdog_en_i = 1'h0;
  logic precharge_timer_en_i = 1'h0, total_charge_timer_en_i = 1'h0;
  logic trickle_time_count_sel_i = 1'h0, safety_timer_clear_i = 1'h0;
  logic state_pin_type_sel_i = 1'h0, state_pin_out_en_i = 1'h0;
  logic [1:0] charge_phase_i = 2'h0, boost_voltage_sel_i = 2'h0;
  logic [12:0] batt_mv_i = 13'h0000;
  logic [6:0] float_voltage_field_i = 7'h00, irq_mask_i = 7'h00, load_val = 7'h00;
  logic [4:0] fast_current_field_i = 5'h00;
  logic keep_alive = 1'h0, auto_clr = 1'h0, load = 1'h0, i2c_ack_i, stat_pin;
  logic [6:0] irq_flags_i;
  logic charge_run_o, recharge_active_o, boost_on_o, boost_error_irq_o, charge_timer_irq_o;
  logic boost_overcurrent_stat_o, boost_thermal_stat_o, boost_wdog_stat_o, wdog_irq_o;
  logic recharge_irq_o, reg_reload_o, state_pin_o, state_pin_oe_o;
  logic [1:0] boost_voltage_o;
  logic [4:0] boost_ilim_o;
  int err_count = 0, samples_checked = 0, seed = 81431, cyc = 0, nexp = 0;
  int n_rchg = 0, n_ctmr = 0, n_rld = 0, n_wdog = 0, n_berr = 0, n_oe = 0, bad = 0;
  logic [12:0] fmv;

  cst_supervisor #(.TICK_CYC(4), .PRE_TICKS(20), .TOT_TICKS(40), .WDOG_TICKS(30)) uut (
    .clk_i, .rst_i, .input_supply_pin_i, .in_uvlo_i, .in_ovlo_i, .dead_battery_threshold_i,
    .limit_boost_pin_i, .boost_batt_ok_i, .boost_oc_i, .batt_ilim_i, .die_hot_i, .startup_ok_i,
    .charge_en_i, .charge_done_i, .charge_phase_i, .batt_mv_i, .float_voltage_field_i,
    .recharge_threshold_sel_i, .auto_recharge_en_i, .auto_charge_en_i, .boost_host_ctrl_i,
    .boost_i2c_en_i, .boost_voltage_sel_i, .fast_current_field_i, .boost_stat_clear_i,
    .i2c_ack_i, .standby_wdog_en_i, .boost_wdog_en_i, .charge_wdog_en_i, .precharge_timer_en_i,
    .total_charge_timer_en_i, .trickle_time_count_sel_i, .safety_timer_clear_i,
    .state_pin_type_sel_i, .state_pin_out_en_i, .irq_flags_i, .irq_mask_i, .charge_run_o,
    .recharge_active_o, .boost_on_o, .boost_voltage_o, .boost_ilim_o, .boost_error_irq_o,
    .boost_overcurrent_stat_o, .boost_thermal_stat_o, .boost_wdog_stat_o, .charge_timer_irq_o,
    .wdog_irq_o, .recharge_irq_o, .reg_reload_o, .state_pin_o, .state_pin_oe_o);

  cst_host_model host (.clk_i, .rst_i, .pin_oe_i(state_pin_oe_o), .keep_alive_i(keep_alive),
    .auto_clear_i(auto_clr), .load_i(load), .load_val_i(load_val), .i2c_ack_o(i2c_ack_i),
    .irq_flags_o(irq_flags_i), .stat_pin_o(stat_pin));

  // ***********************************************
  // clock, pulse monitor, checks and closing
  // ***********************************************
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc++;
    if (recharge_irq_o) n_rchg++;
    if (charge_timer_irq_o) n_ctmr++;
    if (reg_reload_o) n_rld++;
    if (wdog_irq_o) n_wdog++;
    if (boost_error_irq_o) n_berr++;
    if (state_pin_oe_o) n_oe++;
    if ((charge_timer_irq_o || reg_reload_o) && charge_run_o) bad++;
    if (boost_error_irq_o && boost_on_o) bad++;
    if (cyc == 40000) begin
      err_count++;
      end_sim();
    end
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic run(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic boost_req(input logic on);
    limit_boost_pin_i = on & !boost_host_ctrl_i;
    boost_i2c_en_i = on & boost_host_ctrl_i;
    run(5);
  endtask
  function automatic logic [2:0] exp_stat(input int k);
    return (k == 0) ? 3'h4 : (k == 1) ? 3'h2 : (k == 2) ? 3'h1 : 3'h0;
  endfunction
  task automatic end_sim();
    if (err_count == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ***********************************************
  // scenarios
  // ***********************************************
  initial begin
    run(2);
    rst_i = 1'h0;
    float_voltage_field_i = 7'($random(seed));
    fmv = 13'(3500 + 10 * float_voltage_field_i);
    batt_mv_i = fmv;
    {input_supply_pin_i, startup_ok_i, state_pin_out_en_i} = 3'h7;
    charge_phase_i = cst_pkg::PH_FAST;
    // float code settles before charge enable, in scaled time
    run(3);
    charge_en_i = 1'h1;
    run(5);
    chk(charge_run_o, 1'h1);
    chk(state_pin_oe_o, 1'h1);
    {auto_recharge_en_i, standby_wdog_en_i, charge_wdog_en_i, charge_done_i} = 4'hF;
    run(3);
    charge_done_i = 1'h0;
    run(200);
    chk({charge_run_o, state_pin_oe_o, 13'(n_rld)}, 15'h0000);
    {standby_wdog_en_i, charge_wdog_en_i} = 2'h0;
    batt_mv_i = fmv - 13'h008C;
    run(3);
    chk(charge_run_o, 1'h0);
    auto_recharge_en_i = 1'h0;
    batt_mv_i = fmv - 13'h008D;
    run(3);
    chk(charge_run_o, 1'h0);
    auto_recharge_en_i = 1'h1;
    run(1);
    chk({charge_run_o, recharge_active_o}, 2'h3);
    charge_phase_i = cst_pkg::PH_TRICKLE;
    {precharge_timer_en_i, total_charge_timer_en_i, trickle_time_count_sel_i} = 3'h7;
    run(300);
    chk({charge_run_o, 7'(n_rchg), 8'(n_ctmr)}, 16'h8100);
    {charge_en_i, auto_recharge_en_i, total_charge_timer_en_i, trickle_time_count_sel_i} = 4'h0;
    batt_mv_i = fmv;
    run(5);
    charge_en_i = 1'h1;
    run(200);
    chk(charge_run_o, 1'h1);
    trickle_time_count_sel_i = 1'h1;
    for (int i = 0; i < 5; i++) begin
      run(40);
      safety_timer_clear_i = 1'h1;
      run(1);
      safety_timer_clear_i = 1'h0;
    end
    chk({charge_run_o, 8'(n_rld)}, 9'h100);
    charge_phase_i = cst_pkg::PH_PRE;
    run(60);
    charge_phase_i = cst_pkg::PH_FAST;
    run(2);
    charge_phase_i = cst_pkg::PH_PRE;
    run(60);
    chk(charge_run_o, 1'h1);
    run(100);
    chk({charge_run_o, 8'(n_ctmr)}, 9'h001);
    {charge_en_i, precharge_timer_en_i} = 2'h0;
    charge_phase_i = cst_pkg::PH_FAST;
    run(3);
    {charge_en_i, total_charge_timer_en_i} = 2'h3;
    run(120);
    chk(charge_run_o, 1'h1);
    run(80);
    chk({charge_run_o, 8'(n_ctmr)}, 9'h002);
    {charge_en_i, total_charge_timer_en_i, auto_charge_en_i} = 3'h1;
    run(5);
    chk(charge_run_o, 1'h0);
    dead_battery_threshold_i = 1'h1;
    run(5);
    chk(charge_run_o, 1'h1);
    dead_battery_threshold_i = 1'h0;
    run(50);
    chk(charge_run_o, 1'h1);
    charge_done_i = 1'h1;
    run(3);
    chk(charge_run_o, 1'h0);
    {charge_done_i, auto_charge_en_i, charge_en_i, charge_wdog_en_i, keep_alive} = 5'h07;
    run(300);
    chk(16'(n_rld), 16'h0000);
    keep_alive <= 1'h0;
    run(140);
    chk({8'(n_rld), 8'(n_wdog)}, 16'h0101);
    {charge_en_i, charge_wdog_en_i, standby_wdog_en_i} = 3'h1;
    run(140);
    chk(16'(n_rld), 16'h0002);
    {standby_wdog_en_i, boost_host_ctrl_i, boost_batt_ok_i} = 3'h3;
    boost_req(1'h1);
    chk(boost_on_o, 1'h0);
    {input_supply_pin_i, boost_batt_ok_i} = 2'h0;
    run(5);
    chk(boost_on_o, 1'h0);
    boost_req(1'h0);
    boost_batt_ok_i = 1'h1;
    for (int k = 0; k < 5; k++) begin
      boost_host_ctrl_i = k[0];
      boost_voltage_sel_i = 2'($random(seed));
      fast_current_field_i = 5'($random(seed));
      boost_req(1'h1);
      chk({boost_on_o, boost_voltage_o, boost_ilim_o}, {1'h1, boost_voltage_sel_i,
        fast_current_field_i});
      case (k)
        0: boost_oc_i = 1'h1;
        1: die_hot_i = 1'h1;
        2: boost_wdog_en_i = 1'h1;
        3: batt_ilim_i = 1'h1;
        default: in_uvlo_i = 1'h1;
      endcase
      run(k == 2 ? 140 : 5);
      nexp += (k < 3);
      chk({boost_on_o, 8'(n_berr)}, 9'(nexp));
      {boost_oc_i, die_hot_i, boost_wdog_en_i, batt_ilim_i, in_uvlo_i} = 5'h00;
      run(5);
      chk(boost_on_o, 1'h0);
      chk({boost_overcurrent_stat_o, boost_thermal_stat_o, boost_wdog_stat_o},
        exp_stat(k));
      boost_stat_clear_i = 1'h1;
      run(1);
      boost_stat_clear_i = 1'h0;
      boost_req(1'h0);
    end
    chk(16'(n_rld), 16'h0003);
    for (int i = 0; i < 8; i++) begin
      {state_pin_out_en_i, in_uvlo_i, in_ovlo_i} = 3'(i);
      run(5);
      chk(state_pin_oe_o, 1'(i[2] & (i[1] | i[0])));
      chk(stat_pin, !(i[2] & (i[1] | i[0])));
      chk(state_pin_o, 1'h0);
    end
    {state_pin_type_sel_i, in_uvlo_i, in_ovlo_i, state_pin_out_en_i} = 4'h9;
    irq_mask_i = 7'h7F;
    load_val <= 7'($random(seed)) | 7'h01;
    load <= 1'h1;
    run(1);
    load <= 1'h0;
    n_oe = 0;
    run(200);
    chk(16'(n_oe), 16'h0000);
    irq_mask_i = 7'h00;
    run(200);
    chk(n_oe inside {[28:33]}, 1'h1);
    auto_clr <= 1'h1;
    run(28100);
    chk({n_oe inside {[56:66]}, irq_flags_i, 8'(bad)}, 16'h8000);
    end_sim();
  end
endmodule
